// ==== static_burst_regs.vh ====
`ifndef STATIC_BURST_REGS_VH
`define STATIC_BURST_REGS_VH

// bus clock period in ns
`define SBW_CLK_PERIOD_NS 10
// burst length limits, in bus cycles
`define SBW_BURST_MIN 3'h2
`define SBW_BURST_MAX 3'h4
// default pin widths
`define SBW_ADDR_W 28
`define SBW_DATA_W 32
`define SBW_WAIT_W 4
// buffer depth in words
`define SBW_BUF_DEPTH 2
// bit positions inside a buffered word
`define SBW_FLD_WORD 0
`define SBW_FLD_HALF 1
`define SBW_FLD_DATA_LSB 2
// pin reset levels
`define SBW_RST_STROBE_N 1'b1
`define SBW_RST_SELECT_N 1'b1
`define SBW_RST_DIR 1'b0
`define SBW_RST_READY 1'b1

`endif

// ==== write_skid_buffer.v ====
`timescale 1ns/10ps
`default_nettype none

module write_skid_buffer #(
  parameter WIDTH = 62,
  parameter DEPTH = 2
) (
  input wire clk, // bus clock
  input wire rst, // async reset, active high
  input wire ce, // clock enable, freezes state when low
  input wire in_valid, // producer offers a word
  output reg in_ready, // room for a word, registered
  input wire [WIDTH-1:0] in_data, // word from producer
  output wire out_valid, // a word is waiting
  input wire out_ready, // consumer takes the head word
  output wire [WIDTH-1:0] out_data // head word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [1:0] wr_ptr_reg;
  reg [1:0] rd_ptr_reg;
  reg [2:0] count_reg;
  reg [2:0] count_next;
  wire push;
  wire pop;

  ////////////////////////////////////////////////////////////////////////
  // handshakes; ready is a flop so a stalled consumer stops the producer
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != 3'h0);
  assign out_data = mem[rd_ptr_reg[0]];

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 3'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointers wrap on the power-of-two depth
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg <= 3'h0;
      in_ready <= 1'b1;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
      count_reg <= count_next;
      in_ready <= (count_next != DEPTH[2:0]);
    end
  end

  // storage has no reset; only valid entries are ever read
  always @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg[0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ==== static_burst_write.v ====
`timescale 1ns/10ps
`default_nettype none
`include "static_burst_regs.vh"

module static_burst_write #(
  parameter ADDR_W = `SBW_ADDR_W,
  parameter DATA_W = `SBW_DATA_W,
  parameter WAIT_W = `SBW_WAIT_W
) (
  input wire clk, // expansion bus clock
  input wire rst, // async reset, active high
  input wire ce, // clock enable
  input wire [2:0] burst_len, // programmed burst length, 2..4
  input wire [WAIT_W-1:0] wait_states, // programmed wait states per cycle
  input wire wr_valid, // write word offered
  output wire wr_ready, // write word accepted, registered in buffer
  input wire [ADDR_W-1:0] wr_addr, // byte address
  input wire [DATA_W-1:0] wr_data, // write data
  input wire wr_halfword, // halfword access
  input wire wr_word, // word access
  input wire expansion_ready_in, // ready from external device, asynchronous
  output reg [ADDR_W-1:0] addr_out, // address pins
  output reg [DATA_W-1:0] data_out, // data pins, output half
  output reg data_oe, // data pins driven
  output reg halfword_out, // halfword select pin
  output reg word_out, // word select pin
  output reg write_dir, // transfer direction, high for write
  output reg memory_write_strobe_n, // write strobe, active low
  output reg chip_select_n, // chip select, active low
  output reg burst_done // one-clock pulse at end of burst
);

  localparam ST_IDLE = 1'b0;
  localparam ST_ACCESS = 1'b1;
  localparam BUF_W = ADDR_W + DATA_W + 2;

  reg state_reg;
  reg [2:0] beat_reg;
  reg [2:0] len_reg;
  reg [WAIT_W-1:0] wait_cnt_reg;
  reg ready_meta_reg;
  reg ready_sync_reg;
  reg pop;
  wire head_valid;
  wire [BUF_W-1:0] head;
  wire beat_free;

  // keep the programmed length inside the legal range
  function [2:0] clamp_len;
    input [2:0] len;
    begin
      if (len < `SBW_BURST_MIN) begin
        clamp_len = `SBW_BURST_MIN;
      end else if (len > `SBW_BURST_MAX) begin
        clamp_len = `SBW_BURST_MAX;
      end else begin
        clamp_len = len;
      end
    end
  endfunction

  // address field of a buffered word
  function [ADDR_W-1:0] field_addr;
    input [BUF_W-1:0] w;
    begin
      field_addr = w[BUF_W-1 -: ADDR_W];
    end
  endfunction

  // data field of a buffered word
  function [DATA_W-1:0] field_data;
    input [BUF_W-1:0] w;
    begin
      field_data = w[`SBW_FLD_DATA_LSB +: DATA_W];
    end
  endfunction

  // halfword select of a buffered word
  function field_half;
    input [BUF_W-1:0] w;
    begin
      field_half = w[`SBW_FLD_HALF];
    end
  endfunction

  // word select of a buffered word
  function field_word;
    input [BUF_W-1:0] w;
    begin
      field_word = w[`SBW_FLD_WORD];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer so a stalled bus loses no offered word
  write_skid_buffer #(
    .WIDTH(BUF_W),
    .DEPTH(`SBW_BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_addr, wr_data, wr_halfword, wr_word}),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  ////////////////////////////////////////////////////////////////////////
  // first stage catches ready on the falling edge ahead of the transfer
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      ready_meta_reg <= `SBW_RST_READY;
    end else if (ce) begin
      ready_meta_reg <= expansion_ready_in;
    end
  end

  // second stage settles it; only this stage is looked at
  // the pair costs about one and a half clocks of ready latency
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_sync_reg <= `SBW_RST_READY;
    end else if (ce) begin
      ready_sync_reg <= ready_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // waits done and device ready: the current beat may end
  assign beat_free = (wait_cnt_reg == {WAIT_W{1'b0}}) && ready_sync_reg;

  // take the head word at each cycle start
  always @* begin
    pop = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        pop = head_valid;
      end
      ST_ACCESS: begin
        // next beat starts only once wait states and ready both let go
        if (beat_free) begin
          pop = head_valid && (beat_reg < len_reg);
        end
      end
      default: begin
        pop = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencer; stretching happens only at clock edges
  // a beat lasts one clock plus waits plus one per ready-low look
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      beat_reg <= 3'h0;
      len_reg <= `SBW_BURST_MIN;
      wait_cnt_reg <= {WAIT_W{1'b0}};
      addr_out <= {ADDR_W{1'b0}};
      data_out <= {DATA_W{1'b0}};
      data_oe <= 1'b0;
      halfword_out <= 1'b0;
      word_out <= 1'b0;
      write_dir <= `SBW_RST_DIR;
      memory_write_strobe_n <= `SBW_RST_STROBE_N;
      chip_select_n <= `SBW_RST_SELECT_N;
      burst_done <= 1'b0;
    end else if (ce) begin
      burst_done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (head_valid) begin
            // length is latched so a mid-burst change cannot split a burst
            len_reg <= clamp_len(burst_len);
            beat_reg <= 3'h1;
            wait_cnt_reg <= wait_states;
            addr_out <= field_addr(head);
            data_out <= field_data(head);
            halfword_out <= field_half(head);
            word_out <= field_word(head);
            write_dir <= 1'b1;
            data_oe <= 1'b1;
            memory_write_strobe_n <= 1'b0;
            chip_select_n <= 1'b0;
            state_reg <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (wait_cnt_reg != {WAIT_W{1'b0}}) begin
            // programmed waits run before ready is considered
            wait_cnt_reg <= wait_cnt_reg - {{(WAIT_W-1){1'b0}}, 1'b1};
          end else if (!ready_sync_reg) begin
            // device not ready: hold one more clock and look again
            state_reg <= ST_ACCESS;
          end else if (pop) begin
            // back-to-back beat, strobe and select stay asserted
            beat_reg <= beat_reg + 3'h1;
            wait_cnt_reg <= wait_states;
            addr_out <= field_addr(head);
            data_out <= field_data(head);
            halfword_out <= field_half(head);
            word_out <= field_word(head);
          end else begin
            // burst over; strobe and select rise, the other pins keep their last values until the next cycle
            memory_write_strobe_n <= 1'b1;
            chip_select_n <= 1'b1;
            burst_done <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== static_burst_write_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// pin-side checks of the burst writer
module static_burst_write_asserts #(
  parameter ADDR_W = 28,
  parameter DATA_W = 32,
  parameter WAIT_W = 4
) (
  input wire logic clk, // bus clock
  input wire logic rst, // async reset
  input wire logic [WAIT_W-1:0] wait_states, // waits
  input wire logic expansion_ready_in, // ready
  input wire logic [ADDR_W-1:0] addr_out, // address
  input wire logic [DATA_W-1:0] data_out, // data
  input wire logic data_oe, // data driven
  input wire logic halfword_out, // halfword
  input wire logic word_out, // word
  input wire logic write_dir, // direction
  input wire logic memory_write_strobe_n, // strobe
  input wire logic chip_select_n, // select
  input wire logic burst_done // end pulse
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // four ready-low samples inside a beat; needs the sampler delay to settle
  sequence s_stall;
    (!expansion_ready_in && !chip_select_n) [*4];
  endsequence
  sequence s_end;
    chip_select_n && $past(!chip_select_n);
  endsequence
  a_strobe_select: assert property (memory_write_strobe_n == chip_select_n)
    else $error("strobe and select differ");
  a_idle_hold: assert property (chip_select_n && $past(chip_select_n) |->
    $stable(addr_out) && $stable(data_out) && $stable({halfword_out, word_out, write_dir}))
    else $error("pins moved while idle");
  a_end_hold: assert property ($rose(chip_select_n) |-> data_oe && $stable(data_out))
    else $error("data lost at burst end");
  a_drive_dir: assert property (!chip_select_n |-> write_dir && data_oe)
    else $error("write cycle not driven");
  a_done_end: assert property (burst_done |-> s_end)
    else $error("done without burst end");
  a_done_pulse: assert property (burst_done |=> !burst_done)
    else $error("done longer than one clock");
  a_wait_min: assert property ($fell(chip_select_n) && $past(wait_states) != 0 |=>
    !chip_select_n && $stable(addr_out))
    else $error("wait states not counted");
  a_ready_stall: assert property (s_stall |-> $stable(addr_out) && $stable(data_out))
    else $error("transfer while ready low");
endmodule
bind static_burst_write static_burst_write_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
  .WAIT_W(WAIT_W)) static_burst_write_asserts_i (.clk, .rst, .wait_states,
  .expansion_ready_in, .addr_out, .data_out, .data_oe, .halfword_out, .word_out,
  .write_dir, .memory_write_strobe_n, .chip_select_n, .burst_done);
`default_nettype wire

// ==== ready_device.sv ====
`timescale 1ns/10ps
`default_nettype none
// far device: only its ready line matters to the writer
module ready_device (
  input wire logic clk, // bus clock
  input wire logic stall, // bench asks for waits
  output var logic expansion_ready_in // ready to writer
);
  initial expansion_ready_in = 1'b1;
  // skewed off the edge so the writer sees an unclocked input
  always @(posedge clk) expansion_ready_in <= #3 !stall;
endmodule
`default_nettype wire

// ==== static_burst_write_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module static_burst_write_tb_top;
  reg clk = 1'b0, rst = 1'b1, ce = 1'b1, wr_valid = 1'b0, wr_halfword = 1'b0, wr_word = 1'b0;
  reg stall = 1'b0, pcs = 1'b1, rnd = 1'b0;
  reg [2:0] burst_len = 3'h2;
  reg [3:0] wait_states = 4'h1;
  reg [27:0] wr_addr = 28'h0;
  reg [31:0] wr_data = 32'h0, seed = 32'h7867, sr = 32'h7867;
  reg [61:0] cur, prev;
  reg [61:0] exp_q[$];
  wire wr_ready, data_oe, halfword_out, word_out, write_dir, memory_write_strobe_n;
  wire chip_select_n, burst_done, expansion_ready_in;
  wire [27:0] addr_out;
  wire [31:0] data_out;
  integer err_count = 0, compares = 0, cyc = 0, nb = 0, bexp = 0, pend = 0, ticks = 0, k;
  integer blen = 2;
  static_burst_write static_burst_write_i (.clk, .rst, .ce, .burst_len, .wait_states,
    .wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_halfword, .wr_word, .expansion_ready_in,
    .addr_out, .data_out, .data_oe, .halfword_out, .word_out, .write_dir,
    .memory_write_strobe_n, .chip_select_n, .burst_done);
  ready_device ready_device_i (.clk, .stall, .expansion_ready_in);
  ////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // back-to-back words so the buffer never runs dry between beats
  task send(input integer n);
    integer i;
    begin
      pend = n;
      for (i = 0; i < n; i = i + 1) begin
        @(negedge clk);
        seed = lfsr(seed);
        wr_valid = 1'b1;
        wr_addr = wr_addr + 28'h4;
        wr_data = seed;
        {wr_halfword, wr_word} = seed[5:4];
        while (wr_ready !== 1'b1) @(negedge clk);
        exp_q.push_back({wr_halfword, wr_word, wr_addr, wr_data});
      end
      @(negedge clk) wr_valid = 1'b0;
      for (i = 0; i < 400 && (pend > 0 || chip_select_n !== 1'b1); i = i + 1) @(negedge clk);
      @(negedge clk);
      chk(exp_q.size(), 0);
    end
  endtask
  ////////////////////////////////////////////////////////////
  always #5 clk = !clk;
  // hang guard, well above the longest stalled run
  always @(posedge clk) begin
    ticks = ticks + 1;
    if (ticks == 20000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  // long stalls: three quarters of cycles ask for a wait
  always @(negedge clk) begin
    sr = lfsr(sr);
    stall <= rnd && sr[1:0] != 2'h0;
  end
  // reference model: beat order, beat length, beats per burst
  always @(negedge clk) if (!rst) begin
    cur = {halfword_out, word_out, addr_out, data_out};
    if (chip_select_n === 1'b0 && (pcs || cur !== prev)) begin
      if (!pcs && !rnd) chk(cyc, wait_states + 1);
      if (pcs) begin
        // out-of-range lengths are held to the two-to-four window
        blen = burst_len < 3'h2 ? 2 : (burst_len > 3'h4 ? 4 : burst_len);
        bexp = pend < blen ? pend : blen;
        nb = 0;
      end
      chk({write_dir, data_oe, memory_write_strobe_n}, 3'h6);
      chk(cur, exp_q.pop_front());
      nb = nb + 1;
      pend = pend - 1;
      cyc = 0;
    end
    cyc = cyc + 1;
    if (burst_done === 1'b1) begin
      chk(nb, bexp);
      if (!rnd) chk(cyc - 1, wait_states + 1);
    end
    pcs = chip_select_n !== 1'b0;
    prev = cur;
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk({wr_ready, chip_select_n, memory_write_strobe_n}, 3'h7);
    chk({write_dir, data_oe, burst_done}, 3'h0);
    // last two runs program lengths outside the legal window
    for (k = 0; k < 8; k = k + 1) begin
      burst_len = k > 5 ? (k == 6 ? 3'h1 : 3'h7) : 3'(2 + k % 3);
      wait_states = 4'(1 + k % 3);
      rnd = k > 2 && k < 6;
      send(7);
      $display("test len %0d waits %0d stall %0d done", burst_len, wait_states, rnd);
    end
    final_report;
  end
endmodule
`default_nettype wire
